// [logic/cap_card.sv]
// Card end: interprets command headers and steers response retrieval.
// Assumes the application answers each cmd_valid with one app_valid and
// presents rsp_byte combinationally for the index on rsp_idx.
`timescale 1ns/1ps
module cap_card
  import cap_pkg::*;
#(
  parameter logic [8:0] IFS = IFS_DEFAULT,
  parameter logic [8:0] BUF = BUF_DEFAULT
)
(
  input wire logic clk,
  input wire logic rst,
  cap_link_if.card lk,
  output logic cmd_valid,
  output logic [39:0] cmd_hdr,
  output logic din_valid,
  output logic [7:0] din_byte,
  input wire logic app_valid,
  input wire cap_case_t app_case,
  input wire logic [8:0] app_len,
  input wire logic [15:0] app_sw,
  input wire logic [7:0] proactive_len,
  input wire logic toolkit_busy,
  output logic [8:0] rsp_idx,
  input wire logic [7:0] rsp_byte
);
  typedef enum {ST_HDR, ST_APP, ST_TX, ST_CDATA} cap_card_st_t;
  typedef enum {TX_PRE, TX_DATA, TX_SW1, TX_SW2} cap_tx_t;
  typedef struct packed {
    cap_card_st_t st;
    cap_tx_t txs;
    logic [39:0] hdr;
    logic [8:0] cnt;
    logic [8:0] blk;
    logic [8:0] idx;
    logic [8:0] pend;
    cap_case_t cas;
    logic [8:0] len;
    logic [15:0] sw;
    logic internal;
    logic rx_after;
    logic c2t_valid;
    logic [7:0] c2t_byte;
    logic c2t_blk_end;
    logic c2t_last;
    logic cmd_valid;
    logic din_valid;
    logic [7:0] din_byte;
  } cap_card_s_t;

  cap_card_s_t s;
  cap_card_s_t n;
  cap_case_t a_case;
  logic [8:0] a_len;
  logic [15:0] a_sw;
  logic [15:0] a_sw_eff;
  logic [8:0] le;
  logic cl_ok;
  logic cl_data_ok;
  logic cl_err;
  logic [39:0] nh;

  assign a_case = s.internal ? s.cas : app_case;
  assign a_len = s.internal ? s.len : app_len;
  assign a_sw = s.internal ? s.sw : app_sw;
  // A pending proactive command rides on what would have been a plain success.
  assign a_sw_eff = (a_sw == SW_OK && proactive_len != 8'h00) ?
    {SW1_PROACTIVE, proactive_len} : a_sw;
  assign le = (s.hdr[7:0] == 8'h00) ? FULL_LEN : {1'b0, s.hdr[7:0]};

  cap_sw_class u_class (
    .sw(a_sw_eff),
    .ok(cl_ok),
    .warn(),
    .data_ok(cl_data_ok),
    .chk_err(),
    .err(cl_err)
  );

  always_comb
  begin
    n = s;
    nh = s.hdr;
    n.c2t_valid = 1'b0;
    n.c2t_blk_end = 1'b0;
    n.c2t_last = 1'b0;
    n.cmd_valid = 1'b0;
    n.din_valid = 1'b0;
    case (s.st)
      ST_HDR:
      begin
        if (lk.t2c_valid)
        begin
          if (s.cnt < HDR_LEN)
          begin
            nh = {s.hdr[31:0], lk.t2c_byte};
          end
          else
          begin
            n.din_valid = 1'b1;
            n.din_byte = lk.t2c_byte;
          end
          if (lk.t1_mode && lk.t2c_last && s.cnt == HDR_LEN - 9'h002)
          begin
            nh = {s.hdr[23:0], lk.t2c_byte, 8'h00};
          end
          n.hdr = nh;
          n.cnt = s.cnt + 9'h001;
          if (lk.t1_mode ? lk.t2c_last : (s.cnt == HDR_LEN - 9'h001))
          begin
            n.cnt = 9'h000;
            n.st = ST_APP;
            if (nh[31:24] == INS_ENVELOPE && toolkit_busy)
            begin
              n.sw = SW_TOOLKIT_BUSY;
              n.txs = TX_SW1;
              n.blk = 9'h000;
              n.st = ST_TX;
            end
            else if (!lk.t1_mode && nh[31:24] == INS_GET_RESP && s.pend != 9'h000)
            begin
              // The retrieval gets its own fresh status, not the earlier one.
              n.internal = 1'b1;
              n.cas = CASE2;
              n.len = s.pend;
              n.sw = SW_OK;
            end
            else
            begin
              n.pend = 9'h000;
              n.idx = 9'h000;
              n.internal = 1'b0;
              n.cmd_valid = 1'b1;
            end
          end
        end
      end
      ST_APP:
      begin
        if (s.internal || app_valid)
        begin
          n.internal = 1'b0;
          n.cas = a_case;
          n.len = a_len;
          n.sw = a_sw_eff;
          n.rx_after = 1'b0;
          n.blk = 9'h000;
          n.st = ST_TX;
          n.txs = TX_SW1;
          if (lk.t1_mode)
          begin
            // Only these status classes may carry data back.
            if (cl_data_ok && a_len != 9'h000)
            begin
              n.cnt = a_len;
              n.txs = TX_DATA;
            end
          end
          else if (cl_err)
          begin
            n.txs = TX_SW1;
          end
          else if (a_case == CASE3 || a_case == CASE4)
          begin
            n.txs = TX_PRE;
            n.rx_after = 1'b1;
            n.cnt = le;
          end
          else if (a_case == CASE2)
          begin
            if ((s.hdr[7:0] == 8'h00 && a_len < FULL_LEN) || le > a_len)
            begin
              n.sw = {PB_RESEND, a_len[7:0]};
            end
            else if (le == a_len)
            begin
              if (a_len > BUF)
              begin
                n.sw = {PB_MORE, BUF[7:0]};
                n.pend = a_len;
              end
              else
              begin
                n.txs = TX_PRE;
                n.cnt = le;
                n.pend = 9'h000;
              end
            end
            else
            begin
              n.txs = TX_PRE;
              n.cnt = le;
              n.sw = {PB_MORE, 8'(a_len - le)};
              n.pend = a_len - le;
            end
          end
        end
      end
      ST_TX:
      begin
        n.c2t_valid = 1'b1;
        if (lk.t1_mode)
        begin
          n.blk = s.blk + 9'h001;
          if (s.blk == IFS - 9'h001)
          begin
            n.c2t_blk_end = 1'b1;
            n.blk = 9'h000;
          end
        end
        case (s.txs)
          TX_PRE:
          begin
            n.c2t_byte = s.hdr[31:24];
            if (s.rx_after)
            begin
              n.st = ST_CDATA;
            end
            else
            begin
              n.txs = TX_DATA;
            end
          end
          TX_DATA:
          begin
            n.c2t_byte = rsp_byte;
            n.idx = s.idx + 9'h001;
            n.cnt = s.cnt - 9'h001;
            if (s.cnt == 9'h001)
            begin
              n.txs = TX_SW1;
            end
          end
          TX_SW1:
          begin
            n.c2t_byte = s.sw[15:8];
            n.txs = TX_SW2;
          end
          default:
          begin
            n.c2t_byte = s.sw[7:0];
            n.c2t_last = 1'b1;
            n.c2t_blk_end = lk.t1_mode;
            n.cnt = 9'h000;
            n.st = ST_HDR;
          end
        endcase
      end
      default:
      begin
        if (lk.t2c_valid)
        begin
          n.din_valid = 1'b1;
          n.din_byte = lk.t2c_byte;
          n.cnt = s.cnt - 9'h001;
          if (s.cnt == 9'h001)
          begin
            n.st = ST_TX;
            n.txs = TX_SW1;
            if (s.cas == CASE4 && s.len != 9'h000)
            begin
              n.sw = {PB_MORE, s.len[7:0]};
              n.pend = s.len;
              n.idx = 9'h000;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= ST_HDR;
      s.txs <= TX_SW1;
      s.cas <= CASE1;
    end
    else
    begin
      s <= n;
    end
  end

  assign lk.c2t_valid = s.c2t_valid;
  assign lk.c2t_byte = s.c2t_byte;
  assign lk.c2t_blk_end = s.c2t_blk_end;
  assign lk.c2t_last = s.c2t_last;
  assign cmd_valid = s.cmd_valid;
  assign cmd_hdr = s.hdr;
  assign din_valid = s.din_valid;
  assign din_byte = s.din_byte;
  assign rsp_idx = s.idx;
endmodule

// [logic/cap_pkg.sv]
// Constants and types shared by both ends of the command transport.
// Assumes one byte moves per valid cycle on the link, with no back-pressure.
package cap_pkg;
  localparam logic [7:0] PB_MORE = 8'h61;
  localparam logic [7:0] PB_RESEND = 8'h6c;
  localparam logic [7:0] PB_NULL = 8'h60;
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW1_PROACTIVE = 8'h91;
  localparam logic [7:0] SW1_APP = 8'h90;
  localparam logic [7:0] SW1_WARN_A = 8'h62;
  localparam logic [7:0] SW1_WARN_B = 8'h63;
  localparam logic [7:0] SW1_CHK_ERR = 8'h6f;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_TOOLKIT_BUSY = 16'h9300;
  localparam logic [7:0] INS_GET_RESP = 8'hc0;
  localparam logic [7:0] INS_ENVELOPE = 8'hc2;
  localparam logic [7:0] INS_FETCH = 8'h12;
  localparam logic [7:0] INS_TERM_RESULT = 8'h14;
  localparam logic [7:0] CLA_BASIC_MASK = 8'hfc;
  localparam logic [8:0] HDR_LEN = 9'h005;
  localparam logic [8:0] FULL_LEN = 9'h100;
  localparam logic [8:0] IFS_DEFAULT = 9'h020;
  localparam logic [8:0] BUF_DEFAULT = 9'h100;
  typedef enum logic [1:0] {CASE1, CASE2, CASE3, CASE4} cap_case_t;
endpackage

// [logic/cap_link_if.sv]
// Byte link between the terminal transport layer and the card.
// The testbench instantiates it and joins both ends; one byte per valid cycle.
`timescale 1ns/1ps
interface cap_link_if;
  logic t1_mode;
  logic t2c_valid;
  logic [7:0] t2c_byte;
  logic t2c_blk_end;
  logic t2c_last;
  logic c2t_valid;
  logic [7:0] c2t_byte;
  logic c2t_blk_end;
  logic c2t_last;
  modport card (input t1_mode, t2c_valid, t2c_byte, t2c_blk_end, t2c_last,
    output c2t_valid, c2t_byte, c2t_blk_end, c2t_last);
  modport term (output t1_mode, t2c_valid, t2c_byte, t2c_blk_end, t2c_last,
    input c2t_valid, c2t_byte, c2t_blk_end, c2t_last);
endinterface

// [logic/cap_sw_class.sv]
// Status word classifier used by both ends.
// Purely combinational; callers register whatever they drive out.
`timescale 1ns/1ps
module cap_sw_class
  import cap_pkg::*;
(
  input wire logic [15:0] sw,
  output logic ok,
  output logic warn,
  output logic data_ok,
  output logic chk_err,
  output logic err
);
  always_comb
  begin
    ok = (sw == SW_OK);
    warn = (sw[15:8] == SW1_WARN_A) || (sw[15:8] == SW1_WARN_B);
    data_ok = warn || (sw[15:12] == SW1_APP[7:4]);
    chk_err = (sw[15:8] == SW1_CHK_ERR);
    err = !ok && (sw[15:8] != SW1_PROACTIVE);
  end
endmodule

// [logic/cap_term.sv]
// Terminal end: sends commands and follows the card's procedure bytes.
// Assumes the user presents dat_byte combinationally for dat_idx and
// raises req_valid only while busy is low.
`timescale 1ns/1ps
module cap_term
  import cap_pkg::*;
#(
  parameter logic [8:0] IFS = IFS_DEFAULT
)
(
  input wire logic clk,
  input wire logic rst,
  cap_link_if.term lk,
  input wire logic t1_sel,
  input wire logic req_valid,
  input wire cap_case_t req_case,
  input wire logic [31:0] req_hdr,
  input wire logic [7:0] req_lc,
  input wire logic [7:0] req_le,
  output logic [8:0] dat_idx,
  input wire logic [7:0] dat_byte,
  output logic busy,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic done,
  output logic [15:0] done_sw,
  output logic env_pos,
  output logic env_neg
);
  typedef enum {T_IDLE, T_HDR, T_WAIT, T_PB2, T_TXD, T_RXD, T_T1TX, T_T1RX} cap_term_st_t;
  typedef struct packed {
    cap_term_st_t st;
    logic [0:4][7:0] hdr;
    cap_case_t cas;
    logic [8:0] cnt;
    logic [8:0] blk;
    logic [8:0] idx;
    logic [7:0] sw1;
    logic [15:0] ring;
    logic got_data;
    logic env;
    logic t1;
    logic t2c_valid;
    logic [7:0] t2c_byte;
    logic t2c_blk_end;
    logic t2c_last;
    logic busy;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    logic done;
    logic [15:0] done_sw;
    logic env_pos;
    logic env_neg;
  } cap_term_s_t;

  cap_term_s_t s;
  cap_term_s_t n;
  logic [15:0] fin_sw;
  logic c34;
  logic c24;
  logic [8:0] t1_len;
  logic cl_ok;
  logic cl_warn;
  logic cl_chk;
  logic [7:0] req_cla;

  assign c34 = (s.cas == CASE3 || s.cas == CASE4);
  assign c24 = (s.cas == CASE2 || s.cas == CASE4);
  assign t1_len = 9'h004 + (c34 ? {1'b0, s.hdr[4]} + 9'h001 : 9'h000) + {8'h00, c24};
  assign fin_sw = s.t1 ? {s.ring[7:0], lk.c2t_byte} : {s.sw1, lk.c2t_byte};
  // Toolkit fetch and result always travel on the basic channel.
  assign req_cla = (req_hdr[23:16] == INS_FETCH || req_hdr[23:16] == INS_TERM_RESULT) ?
    (req_hdr[31:24] & CLA_BASIC_MASK) : req_hdr[31:24];

  cap_sw_class u_class (
    .sw(fin_sw),
    .ok(cl_ok),
    .warn(cl_warn),
    .data_ok(),
    .chk_err(cl_chk),
    .err()
  );

  always_comb
  begin
    n = s;
    n.t2c_valid = 1'b0;
    n.t2c_blk_end = 1'b0;
    n.t2c_last = 1'b0;
    n.rsp_valid = 1'b0;
    n.done = 1'b0;
    n.env_pos = 1'b0;
    n.env_neg = 1'b0;
    case (s.st)
      T_IDLE:
      begin
        if (req_valid)
        begin
          n.hdr = {req_cla, req_hdr[23:0], (req_case == CASE3 || req_case == CASE4) ?
            req_lc : (req_case == CASE2 ? req_le : 8'h00)};
          n.cas = req_case;
          n.t1 = t1_sel;
          n.env = (req_hdr[23:16] == INS_ENVELOPE);
          n.got_data = 1'b0;
          n.cnt = 9'h000;
          n.blk = 9'h000;
          n.idx = 9'h000;
          n.st = t1_sel ? T_T1TX : T_HDR;
        end
      end
      T_HDR:
      begin
        n.t2c_valid = 1'b1;
        n.t2c_byte = s.hdr[s.cnt[2:0]];
        n.cnt = s.cnt + 9'h001;
        if (s.cnt == HDR_LEN - 9'h001)
        begin
          n.st = T_WAIT;
        end
      end
      T_WAIT:
      begin
        if (lk.c2t_valid)
        begin
          n.cnt = 9'h000;
          if (lk.c2t_byte == PB_NULL)
          begin
            n.st = T_WAIT;
          end
          else if (lk.c2t_byte == s.hdr[1])
          begin
            n.cnt = (s.hdr[4] == 8'h00) ? FULL_LEN : {1'b0, s.hdr[4]};
            n.st = (c34 && s.idx == 9'h000) ? T_TXD : T_RXD;
          end
          else
          begin
            n.sw1 = lk.c2t_byte;
            n.st = T_PB2;
          end
        end
      end
      T_PB2:
      begin
        if (lk.c2t_valid)
        begin
          n.st = T_HDR;
          if (s.sw1 == PB_MORE)
          begin
            n.hdr = {s.hdr[0], INS_GET_RESP, 8'h00, 8'h00, lk.c2t_byte};
            n.cas = CASE2;
          end
          else if (s.sw1 == PB_RESEND)
          begin
            n.hdr[4] = lk.c2t_byte;
          end
          else
          begin
            n.st = T_IDLE;
            n.done = 1'b1;
            n.done_sw = fin_sw;
            n.env_neg = s.env && (cl_chk || (s.got_data && cl_warn));
            n.env_pos = s.env && s.got_data && cl_ok;
          end
        end
      end
      T_TXD:
      begin
        n.t2c_valid = 1'b1;
        n.t2c_byte = dat_byte;
        n.idx = s.idx + 9'h001;
        n.cnt = s.cnt - 9'h001;
        if (s.cnt == 9'h001)
        begin
          n.st = T_WAIT;
        end
      end
      T_RXD:
      begin
        if (lk.c2t_valid)
        begin
          n.rsp_valid = 1'b1;
          n.rsp_byte = lk.c2t_byte;
          n.got_data = 1'b1;
          n.cnt = s.cnt - 9'h001;
          if (s.cnt == 9'h001)
          begin
            n.st = T_WAIT;
          end
        end
      end
      T_T1TX:
      begin
        n.t2c_valid = 1'b1;
        n.cnt = s.cnt + 9'h001;
        n.blk = s.blk + 9'h001;
        if (s.cnt < 9'h004)
        begin
          n.t2c_byte = s.hdr[s.cnt[2:0]];
        end
        else if (c34 && s.cnt == 9'h004)
        begin
          n.t2c_byte = s.hdr[4];
        end
        else if (c34 && s.cnt < 9'h005 + {1'b0, s.hdr[4]})
        begin
          n.t2c_byte = dat_byte;
          n.idx = s.idx + 9'h001;
        end
        else
        begin
          n.t2c_byte = (s.cas == CASE2) ? s.hdr[4] : req_le;
        end
        if (s.blk == IFS - 9'h001)
        begin
          n.t2c_blk_end = 1'b1;
          n.blk = 9'h000;
        end
        if (s.cnt == t1_len - 9'h001)
        begin
          n.t2c_blk_end = 1'b1;
          n.t2c_last = 1'b1;
          n.cnt = 9'h000;
          n.st = T_T1RX;
        end
      end
      default:
      begin
        if (lk.c2t_valid)
        begin
          // Two bytes are held back, since the status ends the chain.
          n.ring = {s.ring[7:0], lk.c2t_byte};
          n.cnt = (s.cnt == 9'h002) ? s.cnt : s.cnt + 9'h001;
          if (s.cnt == 9'h002)
          begin
            n.rsp_valid = 1'b1;
            n.rsp_byte = s.ring[15:8];
            n.got_data = 1'b1;
          end
          if (lk.c2t_last)
          begin
            n.st = T_IDLE;
            n.done = 1'b1;
            n.done_sw = fin_sw;
            n.env_neg = s.env && (cl_chk || ((s.cnt == 9'h002) && cl_warn));
            n.env_pos = s.env && (s.cnt == 9'h002) && cl_ok;
          end
        end
      end
    endcase
    n.busy = (n.st != T_IDLE);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= T_IDLE;
      s.cas <= CASE1;
    end
    else
    begin
      s <= n;
    end
  end

  assign lk.t1_mode = s.t1;
  assign lk.t2c_valid = s.t2c_valid;
  assign lk.t2c_byte = s.t2c_byte;
  assign lk.t2c_blk_end = s.t2c_blk_end;
  assign lk.t2c_last = s.t2c_last;
  assign dat_idx = s.idx;
  assign busy = s.busy;
  assign rsp_valid = s.rsp_valid;
  assign rsp_byte = s.rsp_byte;
  assign done = s.done;
  assign done_sw = s.done_sw;
  assign env_pos = s.env_pos;
  assign env_neg = s.env_neg;
endmodule

// [tb/cap_link_monitor.sv]
// Assertions on the byte link between the terminal and card ends.
// Assumes the testbench wires every link signal in by name beside the interface.
`timescale 1ns/1ps
module cap_link_monitor
  import cap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic t1_mode,
  input wire logic t2c_valid,
  input wire logic [7:0] t2c_byte,
  input wire logic t2c_blk_end,
  input wire logic t2c_last,
  input wire logic c2t_valid,
  input wire logic [7:0] c2t_byte,
  input wire logic c2t_blk_end,
  input wire logic c2t_last
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  card_chain_a:
    assert property (c2t_blk_end |-> c2t_valid && t1_mode)
    else $error("card block end outside a block protocol byte");
  term_chain_a:
    assert property (t2c_blk_end |-> t2c_valid && t1_mode)
    else $error("terminal block end outside a block protocol byte");
  term_last_a:
    assert property (t2c_last |-> t2c_valid && t1_mode ##1 !t2c_valid)
    else $error("terminal command end marker misplaced");
  status_pair_a:
    assert property (c2t_last |-> c2t_valid && $past(c2t_valid))
    else $error("status bytes not sent as a consecutive pair");
  quiet_after_a:
    assert property (c2t_last |=> !c2t_valid [*5])
    else $error("card spoke without a new command header");
  t1_answer_a:
    assert property (t2c_last |-> ##[2:600] c2t_valid)
    else $error("card did not answer a block command");
  mode_hold_a:
    assert property (t2c_valid && $past(t2c_valid) |-> $stable(t1_mode))
    else $error("protocol mode changed inside a command");
  half_duplex_a:
    assert property (c2t_valid |-> !t2c_valid)
    else $error("both ends drove bytes in the same cycle");
endmodule

// [tb/card_apdu_transport_test.sv]
// Self-checking bench: terminal end and card end joined over the link interface.
// Assumes the application side answers each command one cycle after cmd_valid.
`timescale 1ns/1ps
module card_apdu_transport_test
  import cap_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, t1_sel = 1'b0, req_valid = 1'b0, app_valid = 1'b0;
  logic toolkit_busy = 1'b0, cmd_seen = 1'b0, got_done = 1'b0, pos, neg;
  logic cmd_valid, din_valid, busy, rsp_valid, done, env_pos, env_neg;
  cap_case_t req_case = CASE1, app_case = CASE1;
  logic [31:0] req_hdr = 32'h00000000;
  logic [7:0] req_lc = 8'h00, req_le = 8'h00, proactive_len = 8'h00;
  logic [7:0] din_byte, last_din, term_rb, dat_byte, card_rb;
  logic [8:0] app_len = 9'h000, rsp_idx, dat_idx;
  logic [15:0] app_sw = 16'h0000, done_sw;
  logic [39:0] cmd_hdr, last_hdr;
  int err_count = 0, compares = 0, nblk_c, nblk_t, ndin;
  logic [7:0] rq[$];

  cap_link_if lk();
  cap_card u_cap_card (.clk(clk), .rst(rst), .lk(lk), .cmd_valid(cmd_valid),
    .cmd_hdr(cmd_hdr), .din_valid(din_valid), .din_byte(din_byte), .app_valid(app_valid),
    .app_case(app_case), .app_len(app_len), .app_sw(app_sw), .proactive_len(proactive_len),
    .toolkit_busy(toolkit_busy), .rsp_idx(rsp_idx), .rsp_byte(card_rb));
  cap_term u_cap_term (.clk(clk), .rst(rst), .lk(lk), .t1_sel(t1_sel), .req_valid(req_valid),
    .req_case(req_case), .req_hdr(req_hdr), .req_lc(req_lc), .req_le(req_le),
    .dat_idx(dat_idx), .dat_byte(dat_byte), .busy(busy), .rsp_valid(rsp_valid),
    .rsp_byte(term_rb), .done(done), .done_sw(done_sw), .env_pos(env_pos), .env_neg(env_neg));
  cap_link_monitor u_cap_link_monitor (.clk(clk), .rst(rst), .t1_mode(lk.t1_mode),
    .t2c_valid(lk.t2c_valid), .t2c_byte(lk.t2c_byte), .t2c_blk_end(lk.t2c_blk_end),
    .t2c_last(lk.t2c_last), .c2t_valid(lk.c2t_valid), .c2t_byte(lk.c2t_byte),
    .c2t_blk_end(lk.c2t_blk_end), .c2t_last(lk.c2t_last));

  always #50 clk = ~clk;
  // Data sources are pure index patterns so expected bytes follow from the index alone.
  assign dat_byte = 8'ha0 + dat_idx[7:0];
  assign card_rb = 8'h30 + rsp_idx[7:0];

  always @(posedge clk)
  begin
    cmd_seen <= cmd_valid;
    if (cmd_valid) last_hdr <= cmd_hdr;
    if (rsp_valid) rq.push_back(term_rb);
    if (din_valid) last_din <= din_byte;
    if (din_valid) ndin++;
    if (lk.c2t_blk_end) nblk_c++;
    if (lk.t2c_blk_end) nblk_t++;
    if (done)
    begin
      got_done <= 1'b1;
      pos <= env_pos;
      neg <= env_neg;
    end
  end
  always @(negedge clk) app_valid = cmd_seen;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cfg(input cap_case_t c, input logic [8:0] l, input logic [15:0] s);
    app_case = c;
    app_len = l;
    app_sw = s;
  endtask

  task automatic xfer(input logic t1, input cap_case_t c, input logic [31:0] h,
    input logic [7:0] lc, input logic [7:0] le);
    int n;
    rq.delete();
    nblk_c = 0;
    nblk_t = 0;
    ndin = 0;
    got_done = 1'b0;
    @(negedge clk);
    {t1_sel, req_case, req_hdr, req_lc, req_le, req_valid} = {t1, c, h, lc, le, 1'b1};
    @(negedge clk);
    req_valid = 1'b0;
    chk(16'(busy), 16'h0001);
    for (n = 0; n < 3000 && !got_done; n++) @(negedge clk);
    chk(16'(got_done), 16'h0001);
    chk(16'(busy), 16'h0000);
    repeat (10) @(negedge clk);
  endtask

  task automatic s_exact;
    cfg(CASE2, 9'h004, SW_OK);
    xfer(1'b0, CASE2, 32'h00b00000, 8'h00, 8'h04);
    chk(16'(rq.size()), 16'h0004);
    chk({8'h00, rq[3]}, 16'h0033);
    chk(done_sw, 16'h9000);
  endtask

  task automatic s_resend;
    logic [7:0] les[2] = '{8'h08, 8'h00};
    foreach (les[i])
    begin
      cfg(CASE2, 9'h004, SW_OK);
      xfer(1'b0, CASE2, 32'h00b00000, 8'h00, les[i]);
      chk({8'h00, last_hdr[7:0]}, 16'h0004);
      chk(16'(rq.size()), 16'h0004);
    end
  endtask

  task automatic s_short;
    cfg(CASE2, 9'h006, SW_OK);
    xfer(1'b0, CASE2, 32'h00b00000, 8'h00, 8'h02);
    chk(16'(rq.size()), 16'h0006);
    chk({8'h00, rq[5]}, 16'h0035);
    chk(done_sw, 16'h9000);
  endtask

  task automatic s_case4;
    cfg(CASE4, 9'h005, SW_OK);
    xfer(1'b0, CASE4, 32'h00dc0000, 8'h03, 8'h00);
    chk(16'(ndin), 16'h0003);
    chk({8'h00, last_din}, 16'h00a2);
    chk(16'(rq.size()), 16'h0005);
    chk({8'h00, rq[4]}, 16'h0034);
  endtask

  task automatic s_errors;
    cfg(CASE2, 9'h004, 16'h6a82);
    xfer(1'b0, CASE2, 32'h00b00000, 8'h00, 8'h04);
    chk(16'(rq.size()), 16'h0000);
    chk(done_sw, 16'h6a82);
    xfer(1'b1, CASE2, 32'h00b00000, 8'h00, 8'h04);
    chk(16'(rq.size()), 16'h0000);
  endtask

  task automatic s_toolkit;
    proactive_len = 8'h10;
    cfg(CASE1, 9'h000, SW_OK);
    xfer(1'b0, CASE1, 32'h00700000, 8'h00, 8'h00);
    chk(done_sw, 16'h9110);
    proactive_len = 8'h00;
    xfer(1'b0, CASE1, 32'h83120000, 8'h00, 8'h00);
    chk({8'h00, last_hdr[39:32]}, 16'h0080);
    toolkit_busy = 1'b1;
    cfg(CASE3, 9'h000, SW_OK);
    xfer(1'b1, CASE3, 32'h80c20000, 8'h03, 8'h00);
    chk(done_sw, SW_TOOLKIT_BUSY);
    toolkit_busy = 1'b0;
  endtask

  task automatic s_envelope;
    cfg(CASE3, 9'h000, 16'h6f00);
    xfer(1'b0, CASE3, 32'h80c20000, 8'h03, 8'h00);
    chk({15'h0000, neg}, 16'h0001);
    cfg(CASE4, 9'h003, SW_OK);
    xfer(1'b1, CASE4, 32'h80c20000, 8'h03, 8'h00);
    chk({14'h0000, pos, neg}, 16'h0002);
    chk(16'(rq.size()), 16'h0003);
    cfg(CASE4, 9'h003, 16'h6300);
    xfer(1'b1, CASE4, 32'h80c20000, 8'h03, 8'h00);
    chk({14'h0000, pos, neg}, 16'h0001);
  endtask

  // Forty bytes each way exceed one 32 byte block, so both directions must chain.
  task automatic s_chain;
    cfg(CASE4, 9'h028, SW_OK);
    xfer(1'b1, CASE4, 32'h00320000, 8'h28, 8'h28);
    chk(last_hdr[15:0], 16'h0028);
    chk(16'(nblk_t), 16'h0002);
    chk(16'(nblk_c), 16'h0002);
    chk(16'(rq.size()), 16'h0028);
  endtask

  task automatic test_done;
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    s_exact();
    s_resend();
    s_short();
    s_case4();
    s_errors();
    s_toolkit();
    s_envelope();
    s_chain();
    test_done();
  end

  // Fourteen transfers of about a hundred cycles or fewer each finish well inside this span.
  initial
  begin
    #2000000;
    err_count++;
    test_done();
  end
endmodule
